// File: include/idte_pkg.sv
// Behaviour
// RULE1: Info is four consecutive words: mode, source, destination, count
// RULE2: On-chip info: 26 + 2SI + 2DI + reads/writes
// RULE3: Data access: RAM 2, slow byte 3, slow word 6
// RULE4: FE80 to FFFF is the register field
// RULE5: External info adds 20 + 4SI + 4DI
// RULE6: Two priority states, then await instruction end
// RULE7: Instruction wait at most 38 or 74+16m
// RULE8: Handler starts 16/21 or 28+6m/41+10m later
// RULE9: Software writes info where vector points
// RULE10: Software enables, sets priority, then enables source
// RULE11: One transfer per interrupt; CPU interrupt at end
// RULE12: Zero count decrements and wraps to 65536
// RULE13: Handler reloads count or disables source
// RULE14: Clear the peripheral request flag each transfer
// RULE15: Completion interrupt keeps the starting vector
// RULE16: Minimum mode vector: high byte first, page 0
// RULE17: Fixed step order of the transfer cycle
// RULE18: Maximum mode vector four bytes, last two used
// RULE19: Transfer-enable bit is never cleared here
// RULE20: Increment by one for bytes, two for words
// RULE21: External accesses add the current wait count; the vector fetch here always takes 4 states, with no wait added
`default_nettype none
package idte_pkg;
  // Address map
  localparam logic [15:0] IDTE_REGF_LO = 16'hFE80;
  localparam logic [15:0] IDTE_RAM_LO  = 16'hF680;
  localparam logic [15:0] IDTE_RAM_HI  = 16'hFE7F;
  localparam logic [15:0] IDTE_INFO_SRC = 16'h0002;
  localparam logic [15:0] IDTE_INFO_DST = 16'h0004;
  localparam logic [15:0] IDTE_INFO_CNT = 16'h0006;
  localparam logic [15:0] IDTE_VEC_MAX_OFS = 16'h0002;
  // Mode word fields
  localparam int IDTE_MODE_WORD_BIT = 15;
  localparam int IDTE_MODE_SI_BIT   = 14;
  localparam int IDTE_MODE_DI_BIT   = 13;
  // Step lengths in states
  localparam logic [4:0] IDTE_PRIO_STATES = 5'h02;
  localparam logic [4:0] IDTE_STEP_STATES = 5'h04;
  localparam logic [4:0] IDTE_WB_STATES   = 5'h02;
  localparam logic [4:0] IDTE_TAIL_STATES = 5'h02;
  localparam logic [4:0] IDTE_INFO_EXT_ADD = 5'h04;
  localparam logic [4:0] IDTE_RAM_STATES  = 5'h02;
  localparam logic [4:0] IDTE_BYTE_SLOW   = 5'h03;
  localparam logic [4:0] IDTE_WORD_SLOW   = 5'h06;
  // Waits around the cycle
  localparam logic [7:0] IDTE_INSN_ON      = 8'h26;
  localparam logic [7:0] IDTE_INSN_EXT     = 8'h4A;
  localparam logic [7:0] IDTE_INSN_EXT_PER = 8'h10;
  localparam logic [6:0] IDTE_HND_MIN_ON   = 7'h10;
  localparam logic [6:0] IDTE_HND_MAX_ON   = 7'h15;
  localparam logic [6:0] IDTE_HND_MIN_EXT  = 7'h1C;
  localparam logic [6:0] IDTE_HND_MIN_PER  = 7'h06;
  localparam logic [6:0] IDTE_HND_MAX_EXT  = 7'h29;
  localparam logic [6:0] IDTE_HND_MAX_PER  = 7'h0A;
  // Register port
  localparam logic [3:0]  IDTE_REG_CFG  = 4'h0;
  localparam logic [3:0]  IDTE_REG_STAT = 4'h2;
  localparam logic [3:0]  IDTE_REG_CNT  = 4'h4;
  localparam int IDTE_CFG_MAX_BIT   = 0;
  localparam int IDTE_CFG_STACK_BIT = 1;
  localparam int IDTE_CFG_CODE_BIT  = 2;
  localparam int IDTE_CFG_WAIT_LSB  = 4;
  localparam logic [15:0] IDTE_CFG_MASK  = 16'h0037;
  localparam logic [15:0] IDTE_CFG_RESET = 16'h0030;
  localparam int IDTE_STAT_BUSY_BIT = 0;
  localparam int IDTE_STAT_LATE_BIT = 1;
  localparam int IDTE_STAT_DONE_BIT = 2;
  localparam int IDTE_STAT_SRC_LSB  = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRIO, ST_WINS, ST_VEC, ST_MODE, ST_SPTR, ST_SRD,
    ST_SWB, ST_DPTR, ST_DWR, ST_DWB, ST_CNTR, ST_CNTW, ST_TAIL
  } idte_state_t;
endpackage
`default_nettype wire

// File: tb/idte_mem.sv
`default_nettype none
module idte_mem (
  // Clock
  input  wire logic        i_clk,
  // Bus from the engine
  input  wire logic        i_req,
  input  wire logic        i_last,
  input  wire logic        i_wr,
  input  wire logic        i_word,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:65535];
  logic [15:0] last_r = 16'h0000;
  // Idle bus shows the inverse of the last read, so stale data never matches
  always_comb begin
    if (i_req && !i_wr)
      o_rdata = i_word ? {mem[i_addr], mem[i_addr + 16'h0001]} : {8'h00, mem[i_addr]};
    else
      o_rdata = ~last_r;
  end
  // Writes commit on the last cycle of the step, big-endian words
  always @(posedge i_clk) begin
    if (i_req && i_last && i_wr) begin
      mem[i_addr] <= i_word ? i_wdata[15:8] : i_wdata[7:0];
      if (i_word)
        mem[i_addr + 16'h0001] <= i_wdata[7:0];
    end
    if (i_req && i_last && !i_wr)
      last_r <= o_rdata;
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import idte_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_irq_req = 1'b0;
  logic [15:0] i_irq_vec = 16'h0000;
  logic [4:0]  i_irq_src = 5'h00;
  logic        i_insn_end = 1'b0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        flag_clr, cpu_irq, hstart, bus_req, bus_last, bus_wr, bus_word;
  logic [4:0]  clr_src;
  logic [15:0] irq_vec, bus_addr, bus_wdata, bus_rdata, reg_rdata;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0, req_cyc = 0, acc_cyc = 0, irq_at = 0, hs_at = 0;
  logic        irq_seen = 1'b0;
  logic [15:0] vec_seen = 16'h0000;

  always #25 i_clk = ~i_clk;

  idte_engine i_dut (
    .i_clk(i_clk), .i_rst(i_rst),
    .i_irq_req(i_irq_req), .i_irq_vec(i_irq_vec), .i_irq_src(i_irq_src),
    .i_insn_end(i_insn_end),
    .o_flag_clr(flag_clr), .o_flag_clr_src(clr_src), .o_cpu_irq(cpu_irq),
    .o_cpu_irq_vec(irq_vec), .o_handler_start(hstart),
    .o_bus_req(bus_req), .o_bus_last(bus_last), .o_bus_wr(bus_wr),
    .o_bus_word(bus_word), .o_bus_addr(bus_addr), .o_bus_wdata(bus_wdata),
    .i_bus_rdata(bus_rdata),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(reg_rdata)
  );

  idte_mem i_mem (
    .i_clk(i_clk), .i_req(bus_req), .i_last(bus_last), .i_wr(bus_wr),
    .i_word(bus_word), .i_addr(bus_addr), .i_wdata(bus_wdata), .o_rdata(bus_rdata)
  );

  // Cycle bookkeeping for step lengths and handler latency
  always @(posedge i_clk) begin
    cyc++;
    if (bus_req === 1'b1) req_cyc++;
    if (bus_last === 1'b1) acc_cyc++;
    if (cpu_irq === 1'b1) begin
      irq_seen = 1'b1;
      irq_at = cyc;
      vec_seen = irq_vec;
    end
    if (hstart === 1'b1) hs_at = cyc;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    // Read data stand from the cycle after the strobe until the next read
    #1;
    d = reg_rdata;
  endtask

  task automatic put(input logic [15:0] a, input logic [15:0] d);
    i_mem.mem[a] = d[15:8];
    i_mem.mem[a + 16'h0001] = d[7:0];
  endtask

  function automatic logic [15:0] get(input logic [15:0] a);
    return {i_mem.mem[a], i_mem.mem[a + 16'h0001]};
  endfunction

  function automatic int acc(input logic [15:0] a, input logic w, input int m);
    if (a >= IDTE_REGF_LO) return w ? 6 : 3;
    if (a >= IDTE_RAM_LO) return 2;
    return (w ? 6 : 3) + m;
  endfunction

  // Long transfers with slow info stay far below this
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [15:0] rd, vec, vl, ia, sa, da, sd, c, cfg;
    logic [15:0] sb [3];
    logic [15:0] db [3];
    logic [1:0]  m;
    logic        mx, stk, wd, si, di;
    int          ms, md, ext, lat, w, r0, a0;
    sb = '{16'hF900, 16'hFE90, 16'h5000};
    db = '{16'hFA00, 16'hFEC0, 16'h6000};
    void'($urandom(90));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    tick();
    reg_rd(IDTE_REG_CFG, rd);
    check(rd, IDTE_CFG_RESET);
    reg_rd(4'hE, rd);
    check(rd, 16'h0000);
    // A request gone before priority is decided must not start a cycle
    i_irq_req <= 1'b1;
    i_insn_end <= 1'b1;
    tick();
    i_irq_req <= 1'b0;
    r0 = req_cyc;
    repeat (12) tick();
    check(16'(req_cyc - r0), 16'h0000);
    i_insn_end <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      m = 2'($urandom);
      mx = 1'($urandom);
      stk = 1'($urandom);
      wd = 1'($urandom);
      si = 1'($urandom);
      di = 1'($urandom);
      cfg = {10'h000, m, 1'b0, 1'($urandom), stk, mx};
      vec = 16'h00A0 + 16'(2 * ($urandom % 48));
      vl = mx ? (vec << 1) + 16'h0002 : vec;
      ia = ($urandom % 2) ? 16'h4000 : 16'hFB80;
      sa = sb[$urandom % 3] + 16'(2 * ($urandom % 16));
      da = db[$urandom % 3] + 16'(2 * ($urandom % 16));
      sd = 16'($urandom);
      c = (k == 0) ? 16'h0000 : (k < 3) ? 16'h0001 : 16'(1 + $urandom % 3);
      put(vl, ia);
      put(ia, {wd, si, di, 13'h0000});
      put(ia + 16'h0002, sa);
      put(ia + 16'h0004, da);
      put(ia + 16'h0006, c);
      put(sa, sd);
      put(da, ~sd);
      ms = acc(sa, wd, m);
      md = acc(da, wd, m);
      ext = (ia < IDTE_RAM_LO) ? 20 + 4 * si + 4 * di + m * (5 + si + di) : 0;
      lat = stk ? (mx ? 41 + 10 * m : 28 + 6 * m) : (mx ? 21 : 16);
      reg_wr(IDTE_REG_CFG, cfg);
      reg_rd(IDTE_REG_CFG, rd);
      check(rd, cfg & IDTE_CFG_MASK);
      // Clear sticky late and done so each pass is judged alone
      reg_wr(IDTE_REG_STAT, 16'h0006);
      r0 = req_cyc;
      a0 = acc_cyc;
      irq_seen = 1'b0;
      i_irq_req <= 1'b1;
      i_irq_vec <= vec;
      i_irq_src <= 5'($urandom);
      // One pass stalls past every instruction limit
      repeat ((k == 3) ? 140 : 3 + $urandom % 4) tick();
      i_insn_end <= 1'b1;
      w = 0;
      while (flag_clr !== 1'b1 && w < 400) begin
        tick();
        w++;
      end
      check({11'h000, clr_src}, {11'h000, i_irq_src});
      i_irq_req <= 1'b0;
      i_insn_end <= 1'b0;
      repeat (4) tick();
      check({15'h0000, irq_seen}, {15'h0000, c == 16'h0001});
      check(16'(req_cyc - r0), 16'(24 + 2 * si + 2 * di + ms + md + ext));
      check(16'(acc_cyc - a0), 16'(8 + si + di));
      if (c == 16'h0001) begin
        check(vec_seen, vec);
        repeat (lat + 2) tick();
        check(16'(hs_at - irq_at), 16'(lat));
      end
      check(get(ia + 16'h0002), sa + (si ? (wd ? 16'h0002 : 16'h0001) : 16'h0000));
      check(get(ia + 16'h0004), da + (di ? (wd ? 16'h0002 : 16'h0001) : 16'h0000));
      check(get(ia + 16'h0006), c - 16'h0001);
      check(wd ? get(da) : {8'h00, i_mem.mem[da]}, wd ? sd : {8'h00, sd[15:8]});
      reg_rd(IDTE_REG_CNT, rd);
      check(rd, c - 16'h0001);
      reg_rd(IDTE_REG_STAT, rd);
      check(rd, {3'h0, i_irq_src, 5'h00, c == 16'h0001, k == 3, 1'b0});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: verilog/idte_access_time.sv
`default_nettype none
module idte_access_time
  import idte_pkg::*;
(
  // Access
  input  wire logic [15:0] i_addr,
  input  wire logic        i_word,
  input  wire logic [1:0]  i_wait,
  // Timing
  output logic      [4:0]  o_states,
  output logic             o_ext
);
  logic in_ram;
  logic in_regf;

  always_comb begin
    in_ram  = (i_addr >= IDTE_RAM_LO) && (i_addr <= IDTE_RAM_HI);
    in_regf = (i_addr >= IDTE_REGF_LO); // RULE4
    o_ext   = !in_ram && !in_regf;
    if (in_ram) begin
      o_states = IDTE_RAM_STATES; // RULE3
    end else begin
      o_states = i_word ? IDTE_WORD_SLOW : IDTE_BYTE_SLOW; // RULE3
      if (o_ext) begin
        o_states = o_states + {3'h0, i_wait}; // RULE21
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/idte_engine.sv
// Our own choices: the address map and the plain strobed port.
`default_nettype none
module idte_engine
  import idte_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Interrupt controller
  input  wire logic        i_irq_req,
  input  wire logic [15:0] i_irq_vec,
  input  wire logic [4:0]  i_irq_src,
  input  wire logic        i_insn_end,
  // Request flag clear and CPU interrupt
  output logic             o_flag_clr,
  output logic      [4:0]  o_flag_clr_src,
  output logic             o_cpu_irq,
  output logic      [15:0] o_cpu_irq_vec,
  output logic             o_handler_start,
  // On-chip bus master
  output logic             o_bus_req,
  output logic             o_bus_last,
  output logic             o_bus_wr,
  output logic             o_bus_word,
  output logic      [15:0] o_bus_addr,
  output logic      [15:0] o_bus_wdata,
  input  wire logic [15:0] i_bus_rdata,
  // Register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata
);
  typedef struct packed {
    idte_state_t st;
    logic [4:0]  cnt;
    logic [15:0] vec;
    logic [4:0]  src;
    logic [15:0] info;
    logic [15:0] mode;
    logic [15:0] sptr;
    logic [15:0] dptr;
    logic [15:0] data;
    logic [15:0] count;
    logic [15:0] addr;
    logic        wr;
    logic        word;
    logic [15:0] wdata;
    logic        flag_clr;
    logic        cpu_irq;
    logic [6:0]  hcnt;
    logic        hstart;
    logic [7:0]  wcnt;
    logic [15:0] cfg;
    logic        late;
    logic        done;
    logic [4:0]  last_src;
    logic [15:0] rdata;
  } idte_regs_t;

  localparam idte_regs_t IDTE_REGS_RESET = '{
    st: ST_IDLE, cnt: 5'h00, vec: 16'h0000, src: 5'h00, info: 16'h0000,
    mode: 16'h0000, sptr: 16'h0000, dptr: 16'h0000, data: 16'h0000,
    count: 16'h0000, addr: 16'h0000, wr: 1'b0, word: 1'b0,
    wdata: 16'h0000, flag_clr: 1'b0, cpu_irq: 1'b0, hcnt: 7'h00,
    hstart: 1'b0, wcnt: 8'h00, cfg: IDTE_CFG_RESET, late: 1'b0,
    done: 1'b0, last_src: 5'h00, rdata: 16'h0000};

  idte_regs_t  s_r;
  idte_regs_t  s_nxt;
  logic        last;
  logic [1:0]  wait_cnt;
  logic        max_mode;
  logic [15:0] info_addr;
  logic        info_ext;
  logic [4:0]  info_add;
  logic [4:0]  data_states;
  logic [15:0] inc;
  logic [6:0]  m7;
  logic [7:0]  m8;
  logic [6:0]  hnd_delay;
  logic [7:0]  insn_limit;

  assign last     = (s_r.cnt == 5'h01);
  assign wait_cnt = s_r.cfg[IDTE_CFG_WAIT_LSB +: 2];
  assign max_mode = s_r.cfg[IDTE_CFG_MAX_BIT];
  assign m7       = {5'h00, wait_cnt};
  assign m8       = {6'h00, wait_cnt};
  // The info pointer arrives on the bus at the end of the vector step
  assign info_addr = (s_r.st == ST_VEC) ? i_bus_rdata : s_r.info;
  assign info_add  = info_ext ? (IDTE_INFO_EXT_ADD + {3'h0, wait_cnt}) : 5'h00; // RULE5 RULE21
  assign inc       = s_r.mode[IDTE_MODE_WORD_BIT] ? 16'h0002 : 16'h0001; // RULE20

  // Data pointer is on the bus when the data step is entered
  idte_access_time u_data_time (
    .i_addr   (i_bus_rdata),
    .i_word   (s_r.mode[IDTE_MODE_WORD_BIT]),
    .i_wait   (wait_cnt),
    .o_states (data_states),
    .o_ext    ()
  );

  idte_access_time u_info_time (
    .i_addr   (info_addr),
    .i_word   (1'b1),
    .i_wait   (wait_cnt),
    .o_states (),
    .o_ext    (info_ext)
  );

  always_comb begin
    if (s_r.cfg[IDTE_CFG_STACK_BIT]) begin
      hnd_delay = max_mode ? 7'(IDTE_HND_MAX_EXT + IDTE_HND_MAX_PER * m7)
                           : 7'(IDTE_HND_MIN_EXT + IDTE_HND_MIN_PER * m7); // RULE8
    end else begin
      hnd_delay = max_mode ? IDTE_HND_MAX_ON : IDTE_HND_MIN_ON; // RULE8
    end
    insn_limit = s_r.cfg[IDTE_CFG_CODE_BIT] ? 8'(IDTE_INSN_EXT + IDTE_INSN_EXT_PER * m8)
                                           : IDTE_INSN_ON; // RULE7
  end

  always_comb begin
    s_nxt          = s_r;
    s_nxt.flag_clr = 1'b0;
    s_nxt.cpu_irq  = 1'b0;
    s_nxt.hstart   = 1'b0;
    // Register port first so hardware sets below win over clears
    if (i_reg_wr) begin
      case (i_reg_addr)
        IDTE_REG_CFG: s_nxt.cfg = i_reg_wdata & IDTE_CFG_MASK;
        IDTE_REG_STAT: begin
          if (i_reg_wdata[IDTE_STAT_LATE_BIT]) s_nxt.late = 1'b0;
          if (i_reg_wdata[IDTE_STAT_DONE_BIT]) s_nxt.done = 1'b0;
        end
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        IDTE_REG_CFG:  s_nxt.rdata = s_r.cfg;
        IDTE_REG_STAT: s_nxt.rdata = {3'h0, s_r.last_src, 5'h00, s_r.done,
                                      s_r.late, (s_r.st != ST_IDLE)};
        IDTE_REG_CNT:  s_nxt.rdata = s_r.count;
        default:       s_nxt.rdata = 16'h0000;
      endcase
    end
    // Exception entry delay toward the handler
    if (s_r.hcnt != 7'h00) begin
      s_nxt.hcnt = s_r.hcnt - 7'h01;
      if (s_r.hcnt == 7'h01) s_nxt.hstart = 1'b1; // RULE8
    end
    case (s_r.st)
      ST_IDLE: begin
        // One cycle per accepted interrupt
        if (i_irq_req) begin // RULE11
          s_nxt.st  = ST_PRIO;
          s_nxt.cnt = IDTE_PRIO_STATES; // RULE6
          s_nxt.vec = i_irq_vec;
          s_nxt.src = i_irq_src;
        end
      end
      ST_PRIO: begin
        if (last) begin
          // Request gone during the check: nothing to do
          s_nxt.st   = i_irq_req ? ST_WINS : ST_IDLE; // RULE6
          s_nxt.wcnt = 8'h00;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_WINS: begin
        if (i_insn_end) begin // RULE6
          s_nxt.st   = ST_VEC;
          s_nxt.cnt  = IDTE_STEP_STATES;
          s_nxt.wr   = 1'b0;
          s_nxt.word = 1'b1;
          // Page 0 pointer, high byte at the lower address
          s_nxt.addr = max_mode ? ({s_r.vec[14:0], 1'b0} + IDTE_VEC_MAX_OFS)
                                : s_r.vec; // RULE16 RULE18
        end else begin
          if (s_r.wcnt != 8'hFF) s_nxt.wcnt = s_r.wcnt + 8'h01;
          if (s_r.wcnt >= insn_limit) s_nxt.late = 1'b1; // RULE7
        end
      end
      ST_VEC: begin
        if (last) begin
          s_nxt.info = i_bus_rdata;
          s_nxt.st   = ST_MODE; // RULE17
          s_nxt.addr = i_bus_rdata; // RULE1
          s_nxt.cnt  = IDTE_STEP_STATES + info_add; // RULE2 RULE5
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_MODE: begin
        if (last) begin
          s_nxt.mode = i_bus_rdata;
          s_nxt.st   = ST_SPTR;
          s_nxt.addr = s_r.info + IDTE_INFO_SRC; // RULE1
          s_nxt.cnt  = IDTE_STEP_STATES + info_add;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_SPTR: begin
        if (last) begin
          s_nxt.sptr = i_bus_rdata;
          s_nxt.st   = ST_SRD;
          s_nxt.addr = i_bus_rdata;
          s_nxt.word = s_r.mode[IDTE_MODE_WORD_BIT];
          s_nxt.cnt  = data_states; // RULE3
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_SRD: begin
        if (last) begin
          s_nxt.data = s_r.word ? i_bus_rdata : {8'h00, i_bus_rdata[7:0]};
          s_nxt.word = 1'b1;
          if (s_r.mode[IDTE_MODE_SI_BIT]) begin
            s_nxt.sptr  = s_r.sptr + inc; // RULE20
            s_nxt.st    = ST_SWB;
            s_nxt.wr    = 1'b1;
            s_nxt.wdata = s_r.sptr + inc;
            s_nxt.addr  = s_r.info + IDTE_INFO_SRC;
            s_nxt.cnt   = IDTE_WB_STATES + info_add; // RULE2 RULE5
          end else begin
            s_nxt.st   = ST_DPTR;
            s_nxt.addr = s_r.info + IDTE_INFO_DST;
            s_nxt.cnt  = IDTE_STEP_STATES + info_add;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_SWB: begin
        if (last) begin
          s_nxt.st   = ST_DPTR;
          s_nxt.wr   = 1'b0;
          s_nxt.addr = s_r.info + IDTE_INFO_DST; // RULE1
          s_nxt.cnt  = IDTE_STEP_STATES + info_add;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_DPTR: begin
        if (last) begin
          s_nxt.dptr  = i_bus_rdata;
          s_nxt.st    = ST_DWR;
          s_nxt.wr    = 1'b1;
          s_nxt.word  = s_r.mode[IDTE_MODE_WORD_BIT];
          s_nxt.addr  = i_bus_rdata;
          s_nxt.wdata = s_r.data;
          s_nxt.cnt   = data_states; // RULE3
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_DWR: begin
        if (last) begin
          s_nxt.word = 1'b1;
          if (s_r.mode[IDTE_MODE_DI_BIT]) begin
            s_nxt.dptr  = s_r.dptr + inc; // RULE20
            s_nxt.st    = ST_DWB;
            s_nxt.wdata = s_r.dptr + inc;
            s_nxt.addr  = s_r.info + IDTE_INFO_DST;
            s_nxt.cnt   = IDTE_WB_STATES + info_add; // RULE2 RULE5
          end else begin
            s_nxt.st   = ST_CNTR;
            s_nxt.wr   = 1'b0;
            s_nxt.addr = s_r.info + IDTE_INFO_CNT;
            s_nxt.cnt  = IDTE_STEP_STATES + info_add;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_DWB: begin
        if (last) begin
          s_nxt.st   = ST_CNTR;
          s_nxt.wr   = 1'b0;
          s_nxt.addr = s_r.info + IDTE_INFO_CNT; // RULE1
          s_nxt.cnt  = IDTE_STEP_STATES + info_add;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_CNTR: begin
        if (last) begin
          // Zero wraps to FFFF, giving 65536 transfers
          s_nxt.count = i_bus_rdata - 16'h0001; // RULE12
          s_nxt.st    = ST_CNTW;
          s_nxt.wr    = 1'b1;
          s_nxt.wdata = i_bus_rdata - 16'h0001;
          s_nxt.cnt   = IDTE_STEP_STATES + info_add;
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_CNTW: begin
        if (last) begin
          s_nxt.st       = ST_TAIL;
          s_nxt.wr       = 1'b0;
          s_nxt.cnt      = IDTE_TAIL_STATES;
          s_nxt.flag_clr = 1'b1; // RULE14
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      ST_TAIL: begin
        if (last) begin
          // Transfer-enable bits are left alone for software
          s_nxt.st       = ST_IDLE; // RULE19
          s_nxt.last_src = s_r.src;
          if (s_r.count == 16'h0000) begin
            s_nxt.cpu_irq = 1'b1; // RULE11 RULE15
            s_nxt.done    = 1'b1;
            s_nxt.hcnt    = hnd_delay; // RULE8
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 5'h01;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= IDTE_REGS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_bus_req = (s_r.st >= ST_VEC) && (s_r.st <= ST_CNTW);
    o_bus_last = o_bus_req && last;
  end
  assign o_bus_wr        = s_r.wr;
  assign o_bus_word      = s_r.word;
  assign o_bus_addr      = s_r.addr;
  assign o_bus_wdata     = s_r.wdata;
  assign o_flag_clr      = s_r.flag_clr;
  assign o_flag_clr_src  = s_r.src;
  assign o_cpu_irq       = s_r.cpu_irq;
  assign o_cpu_irq_vec   = s_r.vec;
  assign o_handler_start = s_r.hstart;
  assign o_reg_rdata     = s_r.rdata;

  default clocking idte_cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence seq_prio;
    (s_r.st == ST_PRIO) [*2];
  endsequence
  sequence seq_mode_on;
    (s_r.st == ST_MODE) [*4] ##1 (s_r.st == ST_SPTR);
  endsequence

  AST_PRIO_TWO: assert property ((s_r.st == ST_IDLE) && i_irq_req |=> seq_prio) // RULE6
    else $error("priority check not two states");
  AST_VEC_MIN: assert property ($rose(s_r.st == ST_VEC) && !max_mode |-> o_bus_addr == s_r.vec) // RULE16
    else $error("minimum mode vector address wrong");
  AST_VEC_MAX: assert property ($rose(s_r.st == ST_VEC) && max_mode
      |-> o_bus_addr == ({s_r.vec[14:0], 1'b0} + 16'h0002)) // RULE18
    else $error("maximum mode vector address wrong");
  AST_STEP_ON: assert property ((s_r.st == ST_VEC) && last && !info_ext |=> seq_mode_on) // RULE2
    else $error("on-chip info step length wrong");
  AST_STEP_EXT: assert property ((s_r.st == ST_VEC) && last && info_ext
      |=> s_r.cnt == 5'h08 + {3'h0, wait_cnt}) // RULE5
    else $error("external info step length wrong");
  AST_REGF_BYTE: assert property ((s_r.st == ST_SPTR) && last && (i_bus_rdata >= 16'hFE80)
      && !s_r.mode[15] |=> (s_r.st == ST_SRD) [*3] ##1 (s_r.st != ST_SRD)) // RULE3
    else $error("register field byte read not three states");
  AST_CNT_ADDR: assert property ((s_r.st == ST_CNTR) |-> o_bus_addr == s_r.info + 16'h0006) // RULE1
    else $error("count word address wrong");
  AST_WRAP: assert property ((s_r.st == ST_CNTR) && last && (i_bus_rdata == 16'h0000)
      |=> o_bus_wdata == 16'hFFFF) // RULE12
    else $error("zero count did not wrap");
  AST_FLAG: assert property ((s_r.st == ST_CNTW) && last |=> o_flag_clr ##1 !o_flag_clr) // RULE14
    else $error("request flag not cleared once");
  AST_IRQ_VEC: assert property ((s_r.st == ST_TAIL) && last && (s_r.count == 16'h0000)
      |=> o_cpu_irq && (o_cpu_irq_vec == $past(s_r.vec))) // RULE15
    else $error("completion interrupt missing or wrong vector");
  AST_HANDLER: assert property (o_cpu_irq && !max_mode && !s_r.cfg[1]
      |-> ##16 o_handler_start) // RULE8
    else $error("handler start delay wrong");
endmodule
`default_nettype wire
